/* design/crai_core.sv */
// cpu reset sequencing, bus width strap and interrupt acceptance
`timescale 1ns/1ps
`include "crai_defines.svh"
// Summary of operation
// - pc loaded from three vector bytes
// - stack pointer set to 100h
// - mask level set to seven
// - max mode bit set, never cleared
// - register bank pointer cleared to zero
// - fetch from loaded pc, others kept
// - peripherals initialised, ports general, clock high
// - address bus driven at tenth clock
// - internal rom variant uses 16-bit path
// - romless variant latches strap at release
// - strap low: 16-bit bus, region bits
// - strap high: 8-bit bus, bits ignored
// - peripheral space 000000h to 00009fh
// - mask held in status bits 14:12
// - fixed vectors, nonmaskable level seven
// - only highest priority request forwarded
// - accept when level above mask
// - traps taken without mask compare
// - enable writes n, zero means one
// - disable sets mask to seven
// - new mask applies at once
// - accept sets mask level plus one
// - levels zero and seven are disabled
module crai_core
    import crai_pkg::*;
#(
    parameter int NUM_SRC    = 8,
    parameter int MIN_CYC    = `CRAI_RESET_MIN_CYC,
    parameter int ADDR_CLKS  = `CRAI_ADDR_DRIVE_CLKS
) (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   reset_pin_n,
    input  wire logic                   bus_width_strap,
    input  wire logic                   external_rom_select_pin,
    input  wire logic                   vec_rd_valid,
    input  wire logic [7:0]             vec_rd_data,
    input  wire logic [3:0]             region_bus_width_bits,
    input  wire logic [23:0]            io_addr,
    input  wire logic [NUM_SRC-1:0]     src_req,
    input  wire logic [NUM_SRC-1:0][2:0] src_level,
    input  wire logic                   nmi_req,
    input  wire logic                   trap_req,
    input  wire logic [7:0]             trap_vector,
    input  wire logic                   set_mask_instruction,
    input  wire logic [2:0]             set_mask_operand,
    input  wire logic                   mask_all_instruction,
    input  wire logic                   sr_wr_en,
    input  wire logic [15:0]            sr_wr_data,
    output logic                        vec_rd_req,
    output logic [23:0]                 vec_rd_addr,
    output logic [23:0]                 pc,
    output logic [31:0]                 system_stack_pointer,
    output logic [15:0]                 status_word,
    output logic                        fetch_start,
    output logic                        address_drive_en,
    output logic                        peripheral_init,
    output logic                        port_general_mode,
    output logic                        clk_out,
    output logic                        internal_rom_16bit,
    output logic                        port1_data_bus,
    output logic [3:0]                  region_width_16,
    output logic                        io_select,
    output crai_req_t                   fwd_req,
    output crai_ack_t                   ack
);
    logic        accepted;
    logic        released;
    logic [1:0]  strap_sync;
    logic [1:0]  ea_sync;
    crai_state_t state;
    crai_state_t next_state;
    logic [7:0]  addr_cnt;
    logic [7:0]  next_addr_cnt;
    logic        strap_latched;
    logic        next_strap_latched;
    logic [1:0]  clk_div;
    logic [1:0]  next_clk_div;
    logic [23:0] next_pc;
    logic [31:0] next_ssp;
    logic [15:0] next_status;
    logic        next_vec_rd_req;
    logic [23:0] next_vec_rd_addr;
    logic        next_fetch_start;
    logic        next_addr_drive;
    logic        next_port1;
    logic [3:0]  next_region;
    logic        next_io_select;
    crai_req_t   next_fwd;
    crai_ack_t   next_ack;
    logic [2:0]  mask_now;

    crai_reset_filter #(
        .MIN_CYC (MIN_CYC)
    ) u_reset_filter (
        .mclk        (mclk),
        .rst         (rst),
        .reset_pin_n (reset_pin_n),
        .accepted    (accepted),
        .released    (released)
    );

    // level plus one, saturating at the top level
    function automatic logic [2:0] crai_bump(input logic [2:0] lvl);
        return (lvl == `CRAI_LEVEL_TOP) ? `CRAI_LEVEL_TOP : lvl + 3'h1;
    endfunction

    // highest level wins, lowest index breaks ties; nmi always wins
    function automatic crai_req_t crai_pick(input logic [NUM_SRC-1:0] req,
                                            input logic [NUM_SRC-1:0][2:0] lvl,
                                            input logic nmi);
        crai_req_t r;
        r = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (req[i] && lvl[i] != `CRAI_LEVEL_OFF && lvl[i] != `CRAI_LEVEL_TOP
                && (!r.valid || lvl[i] > r.level)) begin
                r.valid  = 1'b1;
                r.level  = lvl[i];
                r.vector = `CRAI_SRC_VECTOR_BASE + 8'(i * 4);
            end
        end
        if (nmi) begin
            r.valid       = 1'b1;
            r.level       = `CRAI_LEVEL_TOP;
            r.vector      = `CRAI_NMI_VECTOR;
            r.nonmaskable = 1'b1;
        end
        return r;
    endfunction

    // second flop of each synchroniser is the only reader of the first
    always_ff @(posedge mclk) begin
        if (rst) begin
            strap_sync <= 2'h0;
            ea_sync    <= 2'h0;
        end else begin
            strap_sync <= {strap_sync[0], bus_width_strap};
            ea_sync    <= {ea_sync[0], external_rom_select_pin};
        end
    end

    always_comb begin
        next_state         = state;
        next_addr_cnt      = addr_cnt;
        next_strap_latched = strap_latched;
        next_clk_div       = clk_div + 2'h1;
        next_pc            = pc;
        next_ssp           = system_stack_pointer;
        next_status        = status_word;
        next_vec_rd_req    = 1'b0;
        next_vec_rd_addr   = vec_rd_addr;
        next_fetch_start   = 1'b0;
        next_addr_drive    = address_drive_en;
        next_ack           = '0;
        next_io_select     = 1'b0;
        mask_now           = status_word[`CRAI_IFF_HI:`CRAI_IFF_LO];

        next_fwd = crai_pick(src_req, src_level, nmi_req);

        // peripheral space decode
        // space starts at address zero, so only the top bound needs a compare
        if (io_addr <= `CRAI_IO_LAST) begin
            next_io_select = 1'b1;
        end

        if (accepted) begin
            next_ssp = `CRAI_SSP_RESET;
            next_status[`CRAI_IFF_HI:`CRAI_IFF_LO] = `CRAI_MASK_RESET;
            next_status[`CRAI_MAX_BIT] = 1'b1;
            next_status[`CRAI_RBP_HI:`CRAI_RBP_LO] = `CRAI_RBP_RESET;
            next_state      = CRAI_S_HOLD;
            next_addr_drive = 1'b0;
            next_addr_cnt   = 8'h00;
            next_clk_div    = 2'h0;
        end else begin
            if (released) begin
                next_strap_latched = strap_sync[1];
            end
            if (!address_drive_en) begin
                next_addr_cnt = addr_cnt + 8'h01;
                if (addr_cnt == 8'(ADDR_CLKS - 1)) begin
                    next_addr_drive = 1'b1;
                end
            end
            unique case (state)
                CRAI_S_HOLD: begin
                    next_state       = CRAI_S_VEC_LO;
                    next_vec_rd_req  = 1'b1;
                    next_vec_rd_addr = `CRAI_VEC_ADDR_LO;
                end
                CRAI_S_VEC_LO: begin
                    next_vec_rd_req = 1'b1;
                    if (vec_rd_valid) begin
                        next_pc[7:0]     = vec_rd_data;
                        next_vec_rd_addr = `CRAI_VEC_ADDR_MID;
                        next_state       = CRAI_S_VEC_MID;
                    end
                end
                CRAI_S_VEC_MID: begin
                    next_vec_rd_req = 1'b1;
                    if (vec_rd_valid) begin
                        next_pc[15:8]    = vec_rd_data;
                        next_vec_rd_addr = `CRAI_VEC_ADDR_HI;
                        next_state       = CRAI_S_VEC_HI;
                    end
                end
                CRAI_S_VEC_HI: begin
                    next_vec_rd_req = 1'b1;
                    if (vec_rd_valid) begin
                        next_pc[23:16]  = vec_rd_data;
                        next_vec_rd_req = 1'b0;
                        next_state      = CRAI_S_ADDR_WAIT;
                    end
                end
                CRAI_S_ADDR_WAIT: begin
                    if (address_drive_en) begin
                        next_fetch_start = 1'b1;
                        next_state       = CRAI_S_RUN;
                    end
                end
                CRAI_S_RUN: begin
                    // max mode stays set whatever software writes
                    if (sr_wr_en) begin
                        next_status = sr_wr_data;
                        next_status[`CRAI_MAX_BIT] = 1'b1;
                    end
                    if (set_mask_instruction) begin
                        mask_now = (set_mask_operand == 3'h0) ? `CRAI_MASK_MIN_EI : set_mask_operand;
                    end
                    if (mask_all_instruction) begin
                        mask_now = `CRAI_LEVEL_TOP;
                    end
                    next_status[`CRAI_IFF_HI:`CRAI_IFF_LO] = mask_now;
                    if (trap_req) begin
                        next_ack.taken   = 1'b1;
                        next_ack.is_trap = 1'b1;
                        next_ack.vector  = trap_vector;
                    // strictly above mask, nmi at seven always
                    end else if (fwd_req.valid && (fwd_req.level > mask_now || fwd_req.nonmaskable)) begin
                        next_ack.taken  = 1'b1;
                        next_ack.level  = fwd_req.level;
                        next_ack.vector = fwd_req.vector;
                        next_status[`CRAI_IFF_HI:`CRAI_IFF_LO] = crai_bump(fwd_req.level);
                    end
                end
            endcase
        end

        if (ea_sync[1]) begin
            next_port1  = 1'b0;
            next_region = region_bus_width_bits;
        end else if (!next_strap_latched) begin
            next_port1  = 1'b1;
            next_region = region_bus_width_bits;
        end else begin
            next_port1  = 1'b0;
            next_region = 4'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state                <= CRAI_S_HOLD;
            addr_cnt             <= 8'h00;
            strap_latched        <= 1'b0;
            clk_div              <= 2'h0;
            pc                   <= 24'h000000;
            system_stack_pointer <= `CRAI_SSP_RESET;
            status_word          <= 16'h0000;
            vec_rd_req           <= 1'b0;
            vec_rd_addr          <= 24'h000000;
            fetch_start          <= 1'b0;
            address_drive_en     <= 1'b0;
            peripheral_init      <= 1'b1;
            port_general_mode    <= 1'b1;
            clk_out              <= 1'b1;
            internal_rom_16bit   <= 1'b0;
            port1_data_bus       <= 1'b0;
            region_width_16      <= 4'h0;
            io_select            <= 1'b0;
            fwd_req              <= '0;
            ack                  <= '0;
        end else begin
            state                <= next_state;
            addr_cnt             <= next_addr_cnt;
            strap_latched        <= next_strap_latched;
            clk_div              <= next_clk_div;
            pc                   <= next_pc;
            system_stack_pointer <= next_ssp;
            status_word          <= next_status;
            vec_rd_req           <= next_vec_rd_req;
            vec_rd_addr          <= next_vec_rd_addr;
            fetch_start          <= next_fetch_start;
            address_drive_en     <= next_addr_drive;
            peripheral_init      <= accepted;
            port_general_mode    <= accepted;
            clk_out              <= accepted | next_clk_div[1];
            internal_rom_16bit   <= ea_sync[1];
            port1_data_bus       <= next_port1;
            region_width_16      <= next_region;
            io_select            <= next_io_select;
            fwd_req              <= next_fwd;
            ack                  <= next_ack;
        end
    end
endmodule

/* design/crai_defines.svh */
// constants for the reset sequencer and interrupt acceptance block
`ifndef CRAI_DEFINES_SVH
`define CRAI_DEFINES_SVH

`define CRAI_RESET_MIN_CYC   10
`define CRAI_ADDR_DRIVE_CLKS 10
`define CRAI_VEC_ADDR_LO     24'hFFFF00
`define CRAI_VEC_ADDR_MID    24'hFFFF01
`define CRAI_VEC_ADDR_HI     24'hFFFF02
`define CRAI_SSP_RESET       32'h00000100
`define CRAI_MASK_RESET      3'h7
`define CRAI_MASK_MIN_EI     3'h1
`define CRAI_LEVEL_TOP       3'h7
`define CRAI_LEVEL_OFF       3'h0
`define CRAI_RBP_RESET       3'h0
`define CRAI_IFF_HI          14
`define CRAI_IFF_LO          12
`define CRAI_MAX_BIT         11
`define CRAI_RBP_HI          10
`define CRAI_RBP_LO          8
`define CRAI_IO_FIRST        24'h000000
`define CRAI_IO_LAST         24'h00009F
`define CRAI_NMI_VECTOR      8'h20
`define CRAI_SRC_VECTOR_BASE 8'h28

`endif

/* design/crai_pkg.sv */
// types shared by the reset sequencer and interrupt acceptance block
package crai_pkg;

    typedef enum logic [2:0] {
        CRAI_S_HOLD,
        CRAI_S_VEC_LO,
        CRAI_S_VEC_MID,
        CRAI_S_VEC_HI,
        CRAI_S_ADDR_WAIT,
        CRAI_S_RUN
    } crai_state_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] level;
        logic [7:0] vector;
        logic       nonmaskable;
    } crai_req_t;

    typedef struct packed {
        logic       taken;
        logic       is_trap;
        logic [2:0] level;
        logic [7:0] vector;
    } crai_ack_t;

endpackage

/* design/crai_reset_filter.sv */
// reset pin synchroniser and minimum low-time filter
`timescale 1ns/1ps
`include "crai_defines.svh"
module crai_reset_filter #(
    parameter int MIN_CYC = `CRAI_RESET_MIN_CYC
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic reset_pin_n,
    output logic      accepted,
    output logic      released
);
    logic        sync_a;
    logic        sync_b;
    logic [15:0] low_cnt;
    logic [15:0] next_low_cnt;
    logic        next_accepted;
    logic        next_released;

    always_comb begin
        next_low_cnt  = low_cnt;
        next_accepted = accepted;
        next_released = 1'b0;
        if (sync_b) begin
            next_low_cnt  = 16'h0000;
            next_accepted = 1'b0;
            next_released = accepted;
        end else if (low_cnt < 16'(MIN_CYC)) begin
            next_low_cnt = low_cnt + 16'h0001;
        end
        if (!sync_b && low_cnt >= 16'(MIN_CYC - 1)) begin
            next_accepted = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_a   <= 1'b1;
            sync_b   <= 1'b1;
            low_cnt  <= 16'h0000;
            accepted <= 1'b1;
            released <= 1'b0;
        end else begin
            sync_a   <= reset_pin_n;
            sync_b   <= sync_a;
            low_cnt  <= next_low_cnt;
            accepted <= next_accepted;
            released <= next_released;
        end
    end
endmodule

/* tb/crai_core_props.sv */
// assertion checker for the reset sequencer and interrupt acceptance core
`timescale 1ns/1ps
module crai_core_props
    import crai_pkg::*;
#(
    parameter int ADDR_CLKS = 10
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        trap_req,
    input  wire logic        set_mask_instruction,
    input  wire logic [2:0]  set_mask_operand,
    input  wire logic        mask_all_instruction,
    input  wire logic        sr_wr_en,
    input  wire logic [23:0] io_addr,
    input  wire logic        vec_rd_req,
    input  wire logic [31:0] system_stack_pointer,
    input  wire logic [15:0] status_word,
    input  wire logic        fetch_start,
    input  wire logic        address_drive_en,
    input  wire logic        peripheral_init,
    input  wire logic        port_general_mode,
    input  wire logic        clk_out,
    input  wire logic        io_select,
    input  crai_req_t        fwd_req,
    input  crai_ack_t        ack
);
    localparam int AD_LO = ADDR_CLKS - 2;
    localparam int AD_HI = ADDR_CLKS + 2;
    logic       run;
    wire        live = run && !peripheral_init;
    wire  [2:0] msk  = status_word[14:12];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // run opens at the first fetch; any reset acceptance closes it
    always_ff @(posedge mclk) run <= (rst || peripheral_init) ? 1'b0 : (fetch_start || run);
    a_fetch_after_vec: assert property (fetch_start |-> address_drive_en && !vec_rd_req && !peripheral_init)
        else $error("fetch started early");
    a_addr_drive_delay: assert property ($fell(peripheral_init) |-> !address_drive_en ##[AD_LO:AD_HI] $rose(address_drive_en))
        else $error("address bus drive out of window");
    a_reset_values: assert property (peripheral_init [*3] |-> system_stack_pointer == 32'h00000100 && status_word[14:8] == 7'h78)
        else $error("reset values wrong");
    a_reset_pins: assert property (peripheral_init |-> clk_out && port_general_mode)
        else $error("pins not in reset state");
    a_io_decode: assert property (1'b1 |=> io_select == ($past(io_addr) <= 24'h00009F))
        else $error("peripheral space decode wrong");
    a_fwd_level_legal: assert property (fwd_req.valid && !fwd_req.nonmaskable |-> fwd_req.level inside {[3'h1:3'h6]})
        else $error("disabled level forwarded");
    a_accept_above_mask: assert property (ack.taken && !ack.is_trap |-> $past(fwd_req.valid) && ack.level == $past(fwd_req.level)
        && ($past(fwd_req.nonmaskable) || $past(set_mask_instruction) || $past(mask_all_instruction) || ack.level > $past(msk)))
        else $error("interrupt taken at or below mask");
    a_mask_plus_one: assert property (ack.taken && !ack.is_trap |-> msk == ((ack.level == 3'h7) ? 3'h7 : ack.level + 3'h1))
        else $error("mask not level plus one");
    a_trap_always: assert property (live && trap_req && !set_mask_instruction && !mask_all_instruction && !sr_wr_en
        |=> ack.taken && ack.is_trap && msk == $past(msk))
        else $error("trap not taken or mask moved");
    a_mask_write: assert property (live && (set_mask_instruction || mask_all_instruction) && !fwd_req.valid && !trap_req
        && !sr_wr_en |=> msk == ($past(mask_all_instruction) ? 3'h7 : ($past(set_mask_operand) == 3'h0) ? 3'h1
        : $past(set_mask_operand))) else $error("mask write wrong");
endmodule
bind crai_core crai_core_props #(.ADDR_CLKS(ADDR_CLKS)) u_props (.mclk, .rst, .trap_req, .set_mask_instruction,
    .set_mask_operand, .mask_all_instruction, .sr_wr_en, .io_addr, .vec_rd_req, .system_stack_pointer, .status_word,
    .fetch_start, .address_drive_en, .peripheral_init, .port_general_mode, .clk_out, .io_select, .fwd_req, .ack);

/* tb/crai_core_tb_top.sv */
// self-checking bench for the reset sequencer and interrupt acceptance core
`timescale 1ns/1ps
module crai_core_tb_top;
    import crai_pkg::*;
    logic            mclk, rst, reset_pin_n, bus_width_strap, external_rom_select_pin, vec_rd_valid, vec_rd_req;
    logic            nmi_req, trap_req, set_mask_instruction, mask_all_instruction, sr_wr_en, fetch_start;
    logic            address_drive_en, peripheral_init, port_general_mode, clk_out, internal_rom_16bit;
    logic            port1_data_bus, io_select;
    logic [1:0]      wait_cyc;
    logic [2:0]      set_mask_operand;
    logic [3:0]      region_bus_width_bits, region_width_16;
    logic [7:0]      vec_rd_data, trap_vector, src_req;
    logic [7:0][2:0] src_level;
    logic [15:0]     sr_wr_data, status_word;
    logic [23:0]     vec_rd_addr, io_addr, pc;
    logic [31:0]     system_stack_pointer;
    crai_req_t       fwd_req;
    crai_ack_t       ack;
    int              n_mismatch, checks, cyc;

    crai_core #(.NUM_SRC(8), .MIN_CYC(4), .ADDR_CLKS(10)) uut (.mclk, .rst, .reset_pin_n, .bus_width_strap,
        .external_rom_select_pin, .vec_rd_valid, .vec_rd_data, .region_bus_width_bits, .io_addr, .src_req, .src_level,
        .nmi_req, .trap_req, .trap_vector, .set_mask_instruction, .set_mask_operand, .mask_all_instruction, .sr_wr_en,
        .sr_wr_data, .vec_rd_req, .vec_rd_addr, .pc, .system_stack_pointer, .status_word, .fetch_start,
        .address_drive_en, .peripheral_init, .port_general_mode, .clk_out, .internal_rom_16bit, .port1_data_bus,
        .region_width_16, .io_select, .fwd_req, .ack);
    crai_vec_rom u_rom (.mclk, .rst, .wait_cyc, .vec_rd_req, .vec_rd_addr, .vec_rd_valid, .vec_rd_data);

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic end_of_test;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // a hung handshake still reaches the closing report
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic boot(input logic ext, input logic strap, input logic [1:0] w);
        int n;
        n = 0;
        @(negedge mclk);
        external_rom_select_pin = ext;
        bus_width_strap = strap;
        wait_cyc = w;
        reset_pin_n = 1'b0;
        // hold the pin low past the minimum
        repeat (12) @(negedge mclk);
        chk(system_stack_pointer, 32'h100);
        chk(32'(status_word[14:8]), 32'h78);
        chk(32'({clk_out, port_general_mode, peripheral_init}), 32'h7);
        reset_pin_n = 1'b1;
        while (fetch_start !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(32'({fetch_start, address_drive_en}), 32'h3);
        chk(32'(pc), 32'h00123456);
        @(negedge mclk);
        bus_width_strap = !strap;
        repeat (6) @(negedge mclk);
        chk(32'({internal_rom_16bit, port1_data_bus}), 32'({ext, !ext && !strap}));
        chk(32'(region_width_16), (!ext && strap) ? 32'h0 : 32'hA);
    endtask

    task automatic setm(input logic s, input logic [2:0] n, input logic a, input logic [2:0] em);
        @(negedge mclk);
        set_mask_instruction = s;
        set_mask_operand = n;
        mask_all_instruction = a;
        @(negedge mclk);
        set_mask_instruction = 1'b0;
        mask_all_instruction = 1'b0;
        chk(32'(status_word[14:12]), 32'(em));
    endtask

    // e packs taken, trap flag and vector of the expected acknowledge
    task automatic act(input int i, input logic [2:0] l, input logic [7:0] also, input logic nm, input logic tr,
                       input logic [9:0] e, input logic [2:0] em);
        logic [9:0] cap;
        cap = 10'h0;
        @(negedge mclk);
        if (i >= 0) begin
            src_level[i] = l;
            src_req = also | (8'h1 << i);
        end
        nmi_req = nm;
        trap_req = tr;
        repeat (4) begin
            @(posedge mclk);
            #1;
            if (ack.taken === 1'b1 && cap[9] === 1'b0) begin
                cap = {1'b1, ack.is_trap, ack.vector};
            end
            @(negedge mclk);
            trap_req = 1'b0;
            if (cap[9]) begin
                src_req = 8'h0;
                nmi_req = 1'b0;
            end
        end
        @(negedge mclk);
        src_req = 8'h0;
        nmi_req = 1'b0;
        repeat (2) @(negedge mclk);
        chk(32'(cap), 32'(e));
        chk(32'(status_word[14:12]), 32'(em));
    endtask

    initial begin
        rst = 1'b1;
        reset_pin_n = 1'b1;
        bus_width_strap = 1'b0;
        external_rom_select_pin = 1'b0;
        wait_cyc = 2'h1;
        region_bus_width_bits = 4'hA;
        io_addr = 24'h0;
        src_req = 8'h0;
        src_level = {3'h1, 3'h1, 3'h4, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1};
        nmi_req = 1'b0;
        trap_req = 1'b0;
        trap_vector = 8'h08;
        set_mask_instruction = 1'b0;
        set_mask_operand = 3'h0;
        mask_all_instruction = 1'b0;
        sr_wr_en = 1'b0;
        sr_wr_data = 16'h0;
        n_mismatch = 0;
        checks = 0;
        cyc = 0;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        repeat (30) @(negedge mclk);
        boot(1'b0, 1'b0, 2'h0);
        boot(1'b0, 1'b1, 2'h2);
        boot(1'b1, 1'b1, 2'h3);
        act(-1, 3'h0, 8'h0, 1'b0, 1'b1, {2'b11, 8'h08}, 3'h7);
        setm(1'b1, 3'h0, 1'b0, 3'h1);
        act(2, 3'h1, 8'h0, 1'b0, 1'b0, 10'h0, 3'h1);
        setm(1'b1, 3'h3, 1'b0, 3'h3);
        act(2, 3'h3, 8'h0, 1'b0, 1'b0, 10'h0, 3'h3);
        act(2, 3'h5, 8'h0, 1'b0, 1'b0, {2'b10, 8'h30}, 3'h6);
        act(1, 3'h7, 8'h0, 1'b0, 1'b0, 10'h0, 3'h6);
        setm(1'b1, 3'h2, 1'b0, 3'h2);
        act(3, 3'h6, 8'h20, 1'b0, 1'b0, {2'b10, 8'h34}, 3'h7);
        setm(1'b1, 3'h1, 1'b0, 3'h1);
        setm(1'b0, 3'h0, 1'b1, 3'h7);
        act(4, 3'h6, 8'h0, 1'b0, 1'b0, 10'h0, 3'h7);
        act(-1, 3'h0, 8'h0, 1'b1, 1'b0, {2'b10, 8'h20}, 3'h7);
        src_level[0] = 3'h2;
        src_req = 8'h1;
        repeat (3) @(negedge mclk);
        set_mask_instruction = 1'b1;
        set_mask_operand = 3'h1;
        @(posedge mclk);
        #1;
        chk(32'(ack.taken), 32'h1);
        @(negedge mclk);
        set_mask_instruction = 1'b0;
        src_req = 8'h0;
        chk(32'(status_word[14:12]), 32'h3);
        // software keeps the max mode bit set and moves the bank pointer
        sr_wr_data = 16'h0D00;
        sr_wr_en = 1'b1;
        @(negedge mclk);
        sr_wr_en = 1'b0;
        @(negedge mclk);
        chk(32'(status_word[11:8]), 32'hD);
        foreach (src_level[k]) begin
            io_addr = {k[0], 15'h0, 8'h9C} + 24'(k);
            @(negedge mclk);
            chk(32'(io_select), 32'(io_addr <= 24'h00009F));
        end
        end_of_test();
    end
endmodule

/* tb/crai_vec_rom.sv */
// vector memory model answering the core's reset-vector byte reads
`timescale 1ns/1ps
module crai_vec_rom (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [1:0]  wait_cyc,
    input  wire logic        vec_rd_req,
    input  wire logic [23:0] vec_rd_addr,
    output logic             vec_rd_valid,
    output logic [7:0]       vec_rd_data
);
    logic [1:0] cnt;
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt          <= 2'h0;
            vec_rd_valid <= 1'b0;
            vec_rd_data  <= 8'h5A;
        end else if (vec_rd_req && !vec_rd_valid && cnt == wait_cyc) begin
            // bytes at three consecutive vector addresses
            cnt          <= 2'h0;
            vec_rd_valid <= 1'b1;
            vec_rd_data  <= (vec_rd_addr == 24'hFFFF00) ? 8'h56 : (vec_rd_addr == 24'hFFFF01) ? 8'h34 :
                            (vec_rd_addr == 24'hFFFF02) ? 8'h12 : 8'hEE;
        end else begin
            // a released data bus must not keep showing its last byte
            cnt          <= (vec_rd_req && !vec_rd_valid) ? cnt + 2'h1 : 2'h0;
            vec_rd_valid <= 1'b0;
            vec_rd_data  <= ~vec_rd_data;
        end
    end
endmodule
